/* File: common/rxf_pkg.sv */
// Package with register map, field positions, reset values and AGC constants.
package rxf_pkg;
    // ==========================================================
    // Register offsets (byte addresses, all printed offsets are index*4).
    localparam logic [7:0] OFF_CHIP_STATUS = 8'h00;
    localparam logic [7:0] OFF_PROTO_SEL = 8'h04;
    localparam logic [7:0] OFF_RX_SPECIAL = 8'h28;
    localparam logic [7:0] OFF_RX_STATUS = 8'h40;
    // Register indices as printed.
    localparam int IDX_CHIP_STATUS = 8'h00;
    localparam int IDX_PROTO_SEL = 8'h01;
    localparam int IDX_RX_SPECIAL = 8'h0A;
    // ==========================================================
    // Reset values.
    localparam logic [7:0] RST_RX_SPECIAL = 8'h40;
    localparam logic [7:0] RST_CHIP_STATUS = 8'h00;
    localparam logic [7:0] RST_PROTO_SEL = 8'h00;
    // ==========================================================
    // Field positions.
    localparam int BIT_LOW_BAND = 7;
    localparam int BIT_MID_BAND = 6;
    localparam int BIT_MANCH_BAND = 5;
    localparam int BIT_HBR = 4;
    localparam int BIT_GAIN_HI = 3;
    localparam int BIT_GAIN_LO = 2;
    localparam int BIT_AGC_LVL = 1;
    localparam int BIT_NO_LIMIT = 0;
    localparam int BIT_AGC_ON = 2;
    // ==========================================================
    // AGC sequence counts and levels.
    localparam logic [3:0] AGC_WINDOW_PULSES = 4'h8;
    localparam logic [2:0] AGC_CMP_STEPS = 3'h4;
    localparam logic [2:0] AGC_GAIN_STEPS = 3'h3;
    localparam logic [2:0] AGC_MULT_LOW = 3'h3;
    localparam logic [2:0] AGC_MULT_HIGH = 3'h5;
    // Band-pass selection codes.
    localparam logic [2:0] BP_DEFAULT = 3'h0;
    localparam logic [2:0] BP_LOW = 3'h1;
    localparam logic [2:0] BP_MID = 3'h2;
    localparam logic [2:0] BP_MANCH = 3'h3;
    localparam logic [2:0] BP_HBR = 3'h4;
    // Gain reduction in dB.
    localparam logic [4:0] HBR_REDUCE_DB = 5'h12;
    localparam logic [4:0] GAIN_STEP_DB = 5'h05;
    typedef enum logic [1:0] {AGC_IDLE, AGC_CMP, AGC_GAIN, AGC_HOLD} rxf_agc_e;
endpackage

/* File: verilog/rxf_top.sv */
// Receiver filter, gain and AGC configuration block with APB register slave.
`timescale 1ns/1ps
// Notes on behaviour
// - Special-setting register loads 0x40 at reset, chip disable, protocol writes.
// - All four filter bits clear selects default 240 kHz to 1.4 MHz band.
// - B7 low band, B6 mid band, B5 Manchester band.
// - B4 selects wide band plus 18 dB gain reduction; here B7 to B5 take band priority and B7 set drops the 18 dB.
// - B3:B2 reduce gain by 0, 5, 10 or 15 dB.
// - B1 sets AGC trigger to three times, else five times threshold.
// - B0 set lets AGC act always; clear limits it to 8 pulses.
// - AGC runs four comparator steps, then three gain reduction steps.
// - AGC arms only after a transmission finishes.
// - Protocol selection applies preset; software may then override register 0x0A.
// - AGC enabled only while chip status bit B2 is set.
// - AGC starts once digitizer level exceeds selected threshold multiple.
module rxf_top (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and front-end status
    input wire logic chip_en,
    input wire logic tx_done,
    input wire logic subcarrier_pulse,
    input wire logic level_over_3x,
    input wire logic level_over_5x,
    // Front-end controls
    output logic [2:0] bp_sel,
    output logic [4:0] gain_reduce_db,
    output logic agc_cmp_adjust,
    output logic agc_gain_step,
    output logic [1:0] agc_gain_level
);
    // ==========================================================
    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    // Each pin has its own chain; the agree stage filters a one-cycle glitch that
    // slips through the metastability stages.
    localparam int N_PINS = 5;
    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_q;
    logic en_q_r, txd_q_r, pul_q_r, l3_q_r, l5_q_r;
    assign pin_raw = {level_over_5x, level_over_3x, subcarrier_pulse, tx_done, chip_en};
    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_sync
            logic [2:0] stage_r;
            logic agreed_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_r <= 3'h0;
                end else begin
                    stage_r <= {stage_r[1:0], pin_raw[gi]};
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    agreed_r <= 1'b0;
                end else if (stage_r[1] == stage_r[2]) begin
                    agreed_r <= stage_r[2];
                end
            end
            assign pin_q[gi] = agreed_r;
        end
    endgenerate
    assign en_q_r = pin_q[0];
    assign txd_q_r = pin_q[1];
    assign pul_q_r = pin_q[2];
    assign l3_q_r = pin_q[3];
    assign l5_q_r = pin_q[4];
    logic txd_d_r, pul_d_r;
    // Both delay flops reset to the idle level of their pins, so no false edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_d_r <= 1'b0;
        end else begin
            txd_d_r <= txd_q_r;
        end
    end
    // Edges come from the filtered copies, so a bounce on a pin cannot count twice.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pul_d_r <= 1'b0;
        end else begin
            pul_d_r <= pul_q_r;
        end
    end
    logic tx_end, pulse_rise;
    assign tx_end = txd_q_r & ~txd_d_r;
    assign pulse_rise = pul_q_r & ~pul_d_r;
    // ==========================================================
    // APB register slave: zero wait states, unmapped reads return zero.
    logic wr_en, rd_en;
    logic [3:0] wr_hit;
    logic [3:0] rd_hit;
    logic [7:0] rx_special_r, chip_status_r, proto_sel_r;
    // One-hot register select: chip status, protocol select, special setting, status.
    // Unmapped offsets decode to zero, so they read as zero and ignore writes.
    function automatic logic [3:0] reg_hit(input logic [7:0] a);
        reg_hit = 4'h0;
        case (a)
            rxf_pkg::OFF_CHIP_STATUS: reg_hit = 4'h1;
            rxf_pkg::OFF_PROTO_SEL: reg_hit = 4'h2;
            rxf_pkg::OFF_RX_SPECIAL: reg_hit = 4'h4;
            rxf_pkg::OFF_RX_STATUS: reg_hit = 4'h8;
            default: reg_hit = 4'h0;
        endcase
    endfunction
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign wr_hit = wr_en ? reg_hit(paddr) : 4'h0;
    assign rd_hit = rd_en ? reg_hit(paddr) : 4'h0;
    // A protocol write or a disabled chip wins over a direct write in the same cycle,
    // so the preset is never half overridden.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_special_r <= rxf_pkg::RST_RX_SPECIAL;
        end else if (!en_q_r) begin
            rx_special_r <= rxf_pkg::RST_RX_SPECIAL;
        end else if (wr_hit[1]) begin
            rx_special_r <= rxf_pkg::RST_RX_SPECIAL;
        end else if (wr_hit[2]) begin
            rx_special_r <= pwdata[7:0];
        end
    end
    // Chip status and protocol select are plain storage here; only the AGC-enable bit
    // and the protocol write strobe act on this block.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_status_r <= rxf_pkg::RST_CHIP_STATUS;
        end else if (wr_hit[0]) begin
            chip_status_r <= pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proto_sel_r <= rxf_pkg::RST_PROTO_SEL;
        end else if (wr_hit[1]) begin
            proto_sel_r <= pwdata[7:0];
        end
    end
    // ==========================================================
    // AGC sequencer.
    rxf_pkg::rxf_agc_e agc_st_r;
    logic [2:0] step_cnt_r;
    logic [3:0] pulse_cnt_r;
    logic armed_r;
    logic [1:0] agc_lvl_r;
    logic agc_on, window_open, over_thr, gain_take;
    assign agc_on = chip_status_r[rxf_pkg::BIT_AGC_ON];
    // Without the no-limit bit the window closes after a fixed number of pulse rises
    // counted from the end of transmission; the start pulse counts too.
    assign window_open = rx_special_r[rxf_pkg::BIT_NO_LIMIT]
        || (pulse_cnt_r < rxf_pkg::AGC_WINDOW_PULSES);
    assign over_thr = rx_special_r[rxf_pkg::BIT_AGC_LVL] ? l3_q_r : l5_q_r;
    assign gain_take = (agc_st_r == rxf_pkg::AGC_GAIN) && window_open && pulse_rise && over_thr;
    // The arm flag stays set across receptions until AGC is switched off; a new
    // transmission end restarts the pulse window and returns the sequencer and gain level to idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
        end else if (!agc_on) begin
            armed_r <= 1'b0;
        end else if (tx_end) begin
            armed_r <= 1'b1;
        end
    end
    // The pulse count saturates, so a long reply cannot wrap and reopen the window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_r <= 4'h0;
        end else if (!agc_on || tx_end) begin
            pulse_cnt_r <= 4'h0;
        end else if (pulse_rise && pulse_cnt_r != 4'hF) begin
            pulse_cnt_r <= pulse_cnt_r + 4'h1;
        end
    end
    // The level rises only on a real gain step, never on a sequencer state change; AGC off or a transmission end clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_lvl_r <= 2'h0;
        end else if (!agc_on || tx_end) begin
            agc_lvl_r <= 2'h0;
        end else if (gain_take) begin
            agc_lvl_r <= agc_lvl_r + 2'h1;
        end
    end
    // The start pulse is the first of four comparator steps; then up to three gain
    // steps follow, each on a pulse that still crosses the threshold.
    rxf_pkg::rxf_agc_e agc_st_nxt;
    logic [2:0] step_cnt_nxt;
    always_comb begin
        agc_st_nxt = agc_st_r;
        step_cnt_nxt = step_cnt_r;
        case (agc_st_r)
            rxf_pkg::AGC_IDLE: begin
                if (armed_r && window_open && over_thr && pulse_rise) begin
                    agc_st_nxt = rxf_pkg::AGC_CMP;
                    step_cnt_nxt = 3'h1;
                end
            end
            // The comparator phase ends on the pulse after the fourth step.
            rxf_pkg::AGC_CMP: begin
                if (!window_open) begin
                    agc_st_nxt = rxf_pkg::AGC_HOLD;
                end else if (pulse_rise) begin
                    if (step_cnt_r == rxf_pkg::AGC_CMP_STEPS) begin
                        agc_st_nxt = rxf_pkg::AGC_GAIN;
                        step_cnt_nxt = 3'h0;
                    end else begin
                        step_cnt_nxt = step_cnt_r + 3'h1;
                    end
                end
            end
            // In the gain phase the step counter counts gain steps from zero.
            rxf_pkg::AGC_GAIN: begin
                if (!window_open) begin
                    agc_st_nxt = rxf_pkg::AGC_HOLD;
                end else if (gain_take) begin
                    if (step_cnt_r + 3'h1 == rxf_pkg::AGC_GAIN_STEPS) begin
                        agc_st_nxt = rxf_pkg::AGC_HOLD;
                    end
                    step_cnt_nxt = step_cnt_r + 3'h1;
                end
            end
            // Hold keeps the reached gain until AGC is switched off or a new transmission ends.
            rxf_pkg::AGC_HOLD: begin
                agc_st_nxt = rxf_pkg::AGC_HOLD;
            end
            default: begin
                agc_st_nxt = rxf_pkg::AGC_IDLE;
                step_cnt_nxt = 3'h0;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_st_r <= rxf_pkg::AGC_IDLE;
        end else if (!agc_on || tx_end) begin
            agc_st_r <= rxf_pkg::AGC_IDLE;
        end else begin
            agc_st_r <= agc_st_nxt;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_r <= 3'h0;
        end else if (!agc_on || tx_end) begin
            step_cnt_r <= 3'h0;
        end else begin
            step_cnt_r <= step_cnt_nxt;
        end
    end
    // ==========================================================
    // Front-end decode, registered onto the outputs.
    // Band priority runs from the narrowest filter bit down; several bits never mix bands.
    function automatic logic [2:0] band_of(input logic [7:0] v);
        if (v[rxf_pkg::BIT_LOW_BAND]) begin
            band_of = rxf_pkg::BP_LOW;
        end else if (v[rxf_pkg::BIT_MID_BAND]) begin
            band_of = rxf_pkg::BP_MID;
        end else if (v[rxf_pkg::BIT_MANCH_BAND]) begin
            band_of = rxf_pkg::BP_MANCH;
        end else if (v[rxf_pkg::BIT_HBR]) begin
            band_of = rxf_pkg::BP_HBR;
        end else begin
            band_of = rxf_pkg::BP_DEFAULT;
        end
    endfunction
    logic [4:0] manual_db;
    logic bp_low_band_sel, gain_reduce_hi, gain_reduce_lo;
    assign bp_low_band_sel = rx_special_r[rxf_pkg::BIT_LOW_BAND];
    assign gain_reduce_hi = rx_special_r[rxf_pkg::BIT_GAIN_HI];
    assign gain_reduce_lo = rx_special_r[rxf_pkg::BIT_GAIN_LO];
    assign manual_db = 5'(rxf_pkg::GAIN_STEP_DB * {gain_reduce_hi, gain_reduce_lo});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_sel <= rxf_pkg::BP_DEFAULT;
        end else begin
            bp_sel <= band_of(rx_special_r);
        end
    end
    // Manual and high-rate reductions stack unless B7 is set; the sum is truncated to the 5-bit field.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_reduce_db <= 5'h00;
        end else if (rx_special_r[rxf_pkg::BIT_HBR] && !bp_low_band_sel) begin
            gain_reduce_db <= 5'(manual_db + rxf_pkg::HBR_REDUCE_DB);
        end else begin
            gain_reduce_db <= manual_db;
        end
    end
    // The AGC outputs follow the sequencer one cycle late, as every output leaves a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_cmp_adjust <= 1'b0;
            agc_gain_step <= 1'b0;
            agc_gain_level <= 2'h0;
        end else begin
            agc_cmp_adjust <= (agc_st_r == rxf_pkg::AGC_CMP);
            agc_gain_step <= gain_take;
            agc_gain_level <= agc_lvl_r;
        end
    end
    // ==========================================================
    // APB read data and answer; reads only return values.
    // One-cycle answer: pready rises in the access phase right after every setup cycle,
    // so a master never waits longer than one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
        end
    end
    // Read data is captured at the end of the setup cycle and nothing else changes,
    // so a read has no effect on filter or AGC state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (rd_hit[0]) begin
                prdata <= {24'h000000, chip_status_r};
            end else if (rd_hit[1]) begin
                prdata <= {24'h000000, proto_sel_r};
            end else if (rd_hit[2]) begin
                prdata <= {24'h000000, rx_special_r};
            end else if (rd_hit[3]) begin
                prdata <= {24'h000000, armed_r, agc_lvl_r, pulse_cnt_r, 1'b0};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

/* File: sim/rxf_asserts.sv */
// Checker with concurrent assertions for the receiver filter, gain and AGC block.
`timescale 1ns/1ps
module rxf_checker (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Front-end status
    input wire logic chip_en,
    input wire logic tx_done,
    input wire logic subcarrier_pulse,
    input wire logic level_over_3x,
    input wire logic level_over_5x,
    // Front-end controls
    input wire logic [2:0] bp_sel,
    input wire logic [4:0] gain_reduce_db,
    input wire logic agc_cmp_adjust,
    input wire logic agc_gain_step,
    input wire logic [1:0] agc_gain_level
);
    logic acc_wr;
    assign acc_wr = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Bus handshake
    ready_once_a: assert property (pready |=> !pready) else $error("pready held too long");
    ready_setup_a: assert property (psel && !penable |=> pready) else $error("access not answered");
    ready_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    no_err_a: assert property (!pslverr) else $error("pslverr raised");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // ==========================================
    // AGC sequence
    cmp_first_a: assert property (agc_cmp_adjust |-> agc_gain_level == 2'h0)
        else $error("gain taken during comparator phase");
    step_moves_a: assert property (agc_gain_step |-> ##[0:1] $changed(agc_gain_level))
        else $error("gain step without level change");
    hold_three_a: assert property (agc_gain_level == 2'h3 && $stable(agc_gain_level) |-> !agc_gain_step)
        else $error("gain step beyond three");
    agc_off_a: assert property (acc_wr && paddr == 8'h00 && !pwdata[2] |-> ##[1:3] agc_gain_level == 2'h0)
        else $error("gain kept with AGC off");
    tx_rearm_a: assert property ($rose(tx_done) |-> ##[1:8] agc_gain_level == 2'h0)
        else $error("gain kept after new transmission");
    step_cov: cover property (agc_gain_step);
    cmp_cov: cover property (agc_cmp_adjust);
    full_cov: cover property (agc_gain_level == 2'h3);
endmodule
bind rxf_top rxf_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_en(chip_en), .tx_done(tx_done), .subcarrier_pulse(subcarrier_pulse),
    .level_over_3x(level_over_3x), .level_over_5x(level_over_5x), .bp_sel(bp_sel),
    .gain_reduce_db(gain_reduce_db), .agc_cmp_adjust(agc_cmp_adjust),
    .agc_gain_step(agc_gain_step), .agc_gain_level(agc_gain_level));

/* File: sim/tb.sv */
// Self-checking testbench for the receiver filter, gain and AGC block.
`timescale 1ns/1ps
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic chip_en = 0, tx_done = 0, sc = 0, ov3 = 0, ov5 = 0, cmp, stp;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [2:0] bp_sel;
    logic [4:0] gdb;
    logic [1:0] lvl;
    int err_count = 0, n_checks = 0, steps = 0, cmps = 0;
    rxf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_en(chip_en), .tx_done(tx_done), .subcarrier_pulse(sc),
        .level_over_3x(ov3), .level_over_5x(ov5), .bp_sel(bp_sel), .gain_reduce_db(gdb),
        .agc_cmp_adjust(cmp), .agc_gain_step(stp), .agc_gain_level(lvl));
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (stp === 1'b1) steps++;
    always @(posedge pclk) if (cmp === 1'b1) cmps++;
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data is taken at the edge where pready is seen.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        q = prdata;
        if (n >= 20) begin err_count++; give_verdict; end
        psel <= 0; penable <= 0;
    endtask
    task t_band(input logic [7:0] v, input logic [2:0] bp, input logic [4:0] db);
        apb(1, 8'h28, {24'h0, v});
        apb(0, 8'h28, 32'h0);
        chk(q, {24'h0, v});
        repeat (3) @(posedge pclk);
        chk({29'h0, bp_sel}, {29'h0, bp});
        chk({27'h0, gdb}, {27'h0, db});
        $display("band test done");
    endtask
    task t_reload;
        apb(1, 8'h28, 32'h13);
        apb(1, 8'h04, 32'h02);
        apb(0, 8'h28, 32'h0);
        chk(q, 32'h40);
        chip_en <= 0;
        repeat (8) @(posedge pclk);
        apb(1, 8'h28, 32'h13);
        apb(0, 8'h28, 32'h0);
        chk(q, 32'h40);
        chip_en <= 1;
        repeat (8) @(posedge pclk);
        apb(1, 8'h04, 32'h03);
        apb(1, 8'h28, 32'h13);
        apb(0, 8'h28, 32'h0);
        chk(q, 32'h13);
        $display("reload test done");
    endtask
    // Quiet pulses come before the level crosses, to test the action window.
    task t_agc(input logic [7:0] v, input logic o3, input logic o5, input logic on,
               input int quiet, input int exp);
        apb(1, 8'h28, {24'h0, v});
        apb(1, 8'h00, {29'h0, on, 2'b00});
        tx_done <= 0; ov3 <= 0; ov5 <= 0;
        repeat (8) @(posedge pclk);
        tx_done <= 1;
        repeat (8) @(posedge pclk);
        steps = 0;
        cmps = 0;
        for (int i = 0; i < quiet + 10; i++) begin
            if (i == quiet) begin ov3 <= o3; ov5 <= o5; end
            sc <= 1;
            repeat (4) @(posedge pclk);
            sc <= 0;
            repeat (4) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        chk({30'h0, lvl}, exp);
        chk(steps, exp);
        chk(cmps, (exp != 0) ? 32'h20 : 32'h0);
        $display("agc test done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'h28, 32'h0);
        chk(q, 32'h40);
        apb(0, 8'h3C, 32'h0);
        chk(q, 32'h0);
        chip_en <= 1;
        repeat (8) @(posedge pclk);
        t_band(8'h00, 3'h0, 5'h00);
        t_band(8'h80, 3'h1, 5'h00);
        t_band(8'h40, 3'h2, 5'h00);
        t_band(8'h20, 3'h3, 5'h00);
        t_band(8'h10, 3'h4, 5'h12);
        t_band(8'h04, 3'h0, 5'h05);
        t_band(8'h08, 3'h0, 5'h0A);
        t_band(8'h1C, 3'h4, 5'h21);
        t_reload;
        t_agc(8'h02, 1, 0, 1, 0, 3);
        t_agc(8'h00, 1, 0, 1, 0, 0);
        t_agc(8'h00, 1, 1, 1, 0, 3);
        t_agc(8'h00, 1, 1, 0, 0, 0);
        t_agc(8'h00, 1, 1, 1, 8, 0);
        t_agc(8'h01, 1, 1, 1, 8, 3);
        give_verdict;
    end
endmodule
